// file: rtl/spic_params.svh
`ifndef SPIC_PARAMS_SVH
`define SPIC_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define ADR_CHIP_IDENTITY 8'h00
`define ADR_REV_ID 8'h01
`define ADR_SYSCTL 8'h02
`define ADR_IRQCTL_L 8'h04
`define ADR_IRQCTL_H 8'h05
`define ADR_IMASK_L 8'h06
`define ADR_IMASK_H 8'h07
`define ADR_IFLAG_L 8'h08
`define ADR_IFLAG_H 8'h09
`define ADR_PMASK_L 8'h0a
`define ADR_PMASK_M 8'h0b
`define ADR_PMASK_H 8'h0c
`define ADR_PFLAG_L 8'h0d
`define ADR_PFLAG_M 8'h0e
`define ADR_PFLAG_H 8'h0f
`define SYSCTL_RST 8'h06
`define SOFT_RST_BIT 7
`define IRQCTL_RST 3'h0
`define IMASK_RST 5'h00
`define GATE_BIT 0
`define TYPE_BIT 1
`define POL_BIT 2
`define DB_T0_NS 30000
`define DB_T1_NS 90000
`define DB_T2_NS 150000
`define DB_T3_NS 210000
`define HIB_IDLE_NS 100000
`define KEY_WAKE_NS 48000
`define IRQ_PULSE_NS 200000
`define GC_ADDR 7'h00
`define GC_RESET_CODE 8'h06
`endif

// file: rtl/spic_pkg.sv
`include "spic_params.svh"
package spic_pkg;
	typedef enum {P_OPER, P_HIBER, P_KEYWAKE, P_KEYCHK} pwr_state_t;
	typedef enum {I_IDLE, I_ADDR, I_REG, I_WDAT, I_RDAT, I_GC} i2c_state_t;

	// Least time in ns to whole clock cycles, rounded up
	function automatic int unsigned ns2cyc(input int unsigned ns);
		return (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	endfunction : ns2cyc
endpackage : spic_pkg

// file: rtl/i2c_reg_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "spic_params.svh"
module i2c_reg_port
	import spic_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h44
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic [7:0] rdData,
	output logic sdaOe,
	output logic [7:0] regAddr,
	output logic [7:0] wrData,
	output logic wrStb,
	output logic rdStb,
	output logic addrHit,
	output logic addrMiss,
	output logic stopSeen,
	output logic gcReset
);
	// ==========================================================
	// Pin synchronisers
	logic sclMeta_ff, sclSync_ff, sclLast_ff;
	logic sdaMeta_ff, sdaSync_ff, sdaLast_ff;
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{sclMeta_ff, sclSync_ff, sclLast_ff} <= 3'h7;
			{sdaMeta_ff, sdaSync_ff, sdaLast_ff} <= 3'h7;
		end
		else
		begin
			{sclMeta_ff, sclSync_ff, sclLast_ff} <= {sclIn, sclMeta_ff, sclSync_ff};
			{sdaMeta_ff, sdaSync_ff, sdaLast_ff} <= {sdaIn, sdaMeta_ff, sdaSync_ff};
		end
	end

	wire sclRise = sclSync_ff & ~sclLast_ff;
	wire sclFall = ~sclSync_ff & sclLast_ff;
	wire startCond = sclSync_ff & sdaLast_ff & ~sdaSync_ff;
	wire stopCond = sclSync_ff & ~sdaLast_ff & sdaSync_ff;

	// ==========================================================
	// Byte engine
	i2c_state_t st_ff, nxt_st;
	logic [3:0] bitCnt_ff, nxt_bitCnt;
	logic [7:0] shift_ff, nxt_shift, nxt_regAddr, nxt_wrData;
	logic ack_ff, nxt_ack, nxt_sdaOe;
	logic nxt_wrStb, nxt_rdStb, nxt_hit, nxt_miss, nxt_stop, nxt_gc;
	wire byteDone = sclFall & (bitCnt_ff == 4'h8) & ~ack_ff;
	wire ackDone = sclFall & ack_ff;
	wire adrMatch = shift_ff[7:1] == DEV_ADDR;
	wire genCall = shift_ff == {`GC_ADDR, 1'b0};

	always_comb
	begin
		nxt_st = st_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_ack = ack_ff;
		nxt_sdaOe = sdaOe;
		nxt_regAddr = regAddr;
		nxt_wrData = wrData;
		{nxt_wrStb, nxt_rdStb, nxt_hit, nxt_miss, nxt_stop, nxt_gc} = 6'h00;
		// Auto-increment after every byte moved
		if (wrStb || rdStb)
			nxt_regAddr = regAddr + 8'h01;
		if (stopCond)
		begin
			nxt_st = I_IDLE;
			nxt_sdaOe = 1'b0;
			nxt_stop = 1'b1;
		end
		else if (startCond)
		begin
			nxt_st = I_ADDR;
			nxt_bitCnt = 4'h0;
			nxt_ack = 1'b0;
			nxt_sdaOe = 1'b0;
		end
		else if (st_ff != I_IDLE)
		begin
			if (sclRise && !ack_ff)
			begin
				nxt_bitCnt = bitCnt_ff + 4'h1;
				if (st_ff != I_RDAT)
					nxt_shift = {shift_ff[6:0], sdaSync_ff};
			end
			if (sclRise && ack_ff && st_ff == I_RDAT && sdaSync_ff)
				nxt_st = I_IDLE;
			if (sclFall && st_ff == I_RDAT && !ack_ff)
			begin
				nxt_ack = bitCnt_ff == 4'h8;
				nxt_shift = {shift_ff[6:0], 1'b1};
				nxt_sdaOe = (bitCnt_ff != 4'h8) & ~shift_ff[6];
			end
			else if (byteDone)
			begin
				nxt_ack = 1'b1;
				nxt_sdaOe = 1'b1;
				case (st_ff)
					I_ADDR:
					begin
						nxt_hit = adrMatch;
						nxt_miss = ~adrMatch & ~genCall;
						if (adrMatch)
							nxt_st = shift_ff[0] ? I_RDAT : I_REG;
						else if (genCall)
							nxt_st = I_GC;
						else
						begin
							nxt_st = I_IDLE;
							nxt_ack = 1'b0;
							nxt_sdaOe = 1'b0;
						end
					end
					I_REG:
					begin
						nxt_regAddr = shift_ff;
						nxt_st = I_WDAT;
					end
					I_WDAT:
					begin
						nxt_wrStb = 1'b1;
						nxt_wrData = shift_ff;
					end
					I_GC: nxt_gc = shift_ff == `GC_RESET_CODE;
					default: nxt_ack = 1'b0;
				endcase
			end
			else if (ackDone)
			begin
				nxt_ack = 1'b0;
				nxt_bitCnt = 4'h0;
				nxt_sdaOe = 1'b0;
				if (st_ff == I_RDAT)
				begin
					nxt_shift = rdData;
					nxt_sdaOe = ~rdData[7];
					nxt_rdStb = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff <= I_IDLE;
			{bitCnt_ff, shift_ff, ack_ff, sdaOe} <= 14'h0000;
			{regAddr, wrData} <= 16'h0000;
			{wrStb, rdStb, addrHit, addrMiss, stopSeen, gcReset} <= 6'h00;
		end
		else
		begin
			st_ff <= nxt_st;
			{bitCnt_ff, shift_ff, ack_ff, sdaOe} <=
				{nxt_bitCnt, nxt_shift, nxt_ack, nxt_sdaOe};
			{regAddr, wrData} <= {nxt_regAddr, nxt_wrData};
			{wrStb, rdStb, addrHit, addrMiss, stopSeen, gcReset} <=
				{nxt_wrStb, nxt_rdStb, nxt_hit, nxt_miss, nxt_stop, nxt_gc};
		end
	end
endmodule : i2c_reg_port
`default_nettype wire

// file: rtl/system_power_irq_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "spic_params.svh"
module system_power_irq_control
	import spic_pkg::*;
#(
	parameter int unsigned NUM_PINS = 18,
	parameter logic [7:0] CHIP_IDENTITY_VAL = 8'h5a, // Arbitrary value
	parameter logic [7:0] REV_ID_VAL = 8'h03, // Arbitrary value
	parameter logic [6:0] DEV_ADDR = 7'h44, // Arbitrary value
	parameter int unsigned DB_CYC0 = ns2cyc(`DB_T0_NS),
	parameter int unsigned DB_CYC1 = ns2cyc(`DB_T1_NS),
	parameter int unsigned DB_CYC2 = ns2cyc(`DB_T2_NS),
	parameter int unsigned DB_CYC3 = ns2cyc(`DB_T3_NS),
	parameter int unsigned HIB_CYC = ns2cyc(`HIB_IDLE_NS),
	parameter int unsigned KEYWAKE_CYC = ns2cyc(`KEY_WAKE_NS),
	parameter int unsigned PULSE_CYC = ns2cyc(`IRQ_PULSE_NS)
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic extResetPinB,
	input wire logic lowVoltageDet,
	input wire logic keyHeld,
	input wire logic keyFifoEmpty,
	input wire logic [4:0] irqSrcEvt,
	input wire logic [NUM_PINS-1:0] hotKeyPins,
	output logic clkRun,
	output logic oscOn,
	output logic hibernating,
	output logic blockReset,
	output logic [1:0] debounceSel,
	output logic irqPinOut,
	output logic irqPinOe
);
	localparam logic [7:0] SYSCTL_INIT = `SYSCTL_RST;

	if (NUM_PINS < 1 || NUM_PINS > 24 || DB_CYC0 < 1 || DB_CYC3 > 65535 ||
		HIB_CYC < 1 || HIB_CYC > 65535 || KEYWAKE_CYC < 1 ||
		KEYWAKE_CYC > 65535 || PULSE_CYC < 1 || PULSE_CYC > 65535)
	begin : g_bad_param
		$error("system_power_irq_control: parameter out of range");
	end

	function automatic logic [15:0] dbCycles(input logic [1:0] sel);
		case (sel)
			2'b00: dbCycles = 16'(DB_CYC0);
			2'b01: dbCycles = 16'(DB_CYC1);
			2'b10: dbCycles = 16'(DB_CYC2);
			default: dbCycles = 16'(DB_CYC3);
		endcase
	endfunction : dbCycles

	// ==========================================================
	// Register port
	logic [7:0] regAddr, wrData, rdMux;
	logic wrStb, rdStb, addrHit, addrMiss, stopSeen, gcReset;

	i2c_reg_port #(.DEV_ADDR(DEV_ADDR)) u_port (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.rdData(rdMux),
		.sdaOe(sdaOe),
		.regAddr(regAddr),
		.wrData(wrData),
		.wrStb(wrStb),
		.rdStb(rdStb),
		.addrHit(addrHit),
		.addrMiss(addrMiss),
		.stopSeen(stopSeen),
		.gcReset(gcReset)
	);

	// ==========================================================
	// Reset sources and synchronisers
	logic extMeta_ff, extSync_ff, lvdMeta_ff, lvdSync_ff, sysRst_ff;
	logic [NUM_PINS-1:0] pinMeta_ff, pinSync_ff;
	logic softRst_ff, sdaOut_ff;
	wire nxt_sysRst = ~extSync_ff | lvdSync_ff | softRst_ff | gcReset;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{extMeta_ff, extSync_ff, lvdMeta_ff, lvdSync_ff} <= 4'hc;
			{sysRst_ff, sdaOut_ff} <= 2'b00;
			pinMeta_ff <= '0;
			pinSync_ff <= '0;
		end
		else
		begin
			{extMeta_ff, extSync_ff} <= {extResetPinB, extMeta_ff};
			{lvdMeta_ff, lvdSync_ff} <= {lowVoltageDet, lvdMeta_ff};
			{sysRst_ff, sdaOut_ff} <= {nxt_sysRst, 1'b0};
			pinMeta_ff <= hotKeyPins;
			pinSync_ff <= pinMeta_ff;
		end
	end
	assign blockReset = sysRst_ff;
	assign sdaOut = sdaOut_ff;

	// ==========================================================
	// Configuration registers
	logic [1:0] dbSel_ff;
	logic [2:0] irqCtl_ff;
	logic [4:0] irqMask_ff, irqFlags_ff;
	logic [NUM_PINS-1:0] pinMask_ff, pinFlags_ff, pinEvt;
	wire [23:0] pinMaskW = 24'(pinMask_ff);
	wire [23:0] pinFlagsW = 24'(pinFlags_ff);
	wire wrSys = wrStb && regAddr == `ADR_SYSCTL;
	wire wrCtl = wrStb && regAddr == `ADR_IRQCTL_L;
	wire wrMask = wrStb && regAddr == `ADR_IMASK_L;
	wire rdFlags = rdStb && regAddr == `ADR_IFLAG_L;
	wire [23:0] pinWrSel = {{8{wrStb && regAddr == `ADR_PMASK_H}},
		{8{wrStb && regAddr == `ADR_PMASK_M}},
		{8{wrStb && regAddr == `ADR_PMASK_L}}};
	wire [23:0] pinClrSel = {{8{rdStb && regAddr == `ADR_PFLAG_H}},
		{8{rdStb && regAddr == `ADR_PFLAG_M}},
		{8{rdStb && regAddr == `ADR_PFLAG_L}}};
	wire [NUM_PINS-1:0] nxt_pinMask =
		NUM_PINS'((pinMaskW & ~pinWrSel) | ({3{wrData}} & pinWrSel));
	wire [4:0] irqSet = irqSrcEvt | {1'b0, |(pinEvt & pinMask_ff), 3'h0};
	// Set wins over a read clearing the same bit
	wire [4:0] nxt_irqFlags = (irqFlags_ff & ~{5{rdFlags}}) | irqSet;
	wire [NUM_PINS-1:0] nxt_pinFlags =
		(pinFlags_ff & ~NUM_PINS'(pinClrSel)) | pinEvt;
	wire nxt_softRst = (wrSys & wrData[`SOFT_RST_BIT]) |
		(softRst_ff & ~sysRst_ff);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dbSel_ff <= SYSCTL_INIT[2:1];
			{softRst_ff, irqCtl_ff, irqMask_ff} <= {1'b0, `IRQCTL_RST, `IMASK_RST};
			{irqFlags_ff, pinMask_ff, pinFlags_ff} <= '0;
		end
		else if (sysRst_ff)
		begin
			dbSel_ff <= SYSCTL_INIT[2:1];
			{softRst_ff, irqCtl_ff, irqMask_ff} <= {1'b0, `IRQCTL_RST, `IMASK_RST};
			{irqFlags_ff, pinMask_ff, pinFlags_ff} <= '0;
		end
		else
		begin
			softRst_ff <= nxt_softRst;
			dbSel_ff <= wrSys ? wrData[2:1] : dbSel_ff;
			irqCtl_ff <= wrCtl ? wrData[2:0] : irqCtl_ff;
			irqMask_ff <= wrMask ? wrData[4:0] : irqMask_ff;
			{irqFlags_ff, pinMask_ff, pinFlags_ff} <=
				{nxt_irqFlags, nxt_pinMask, nxt_pinFlags};
		end
	end
	assign debounceSel = dbSel_ff;

	// Read mux; IRQCTL, IMASK and IFLAG high bytes and gaps read zero
	always_comb
	begin
		if (regAddr == `ADR_CHIP_IDENTITY)
			rdMux = CHIP_IDENTITY_VAL;
		else if (regAddr == `ADR_REV_ID)
			rdMux = REV_ID_VAL;
		else if (regAddr == `ADR_SYSCTL)
			rdMux = {softRst_ff, 4'h0, dbSel_ff, 1'b0};
		else if (regAddr == `ADR_IRQCTL_L)
			rdMux = {5'h00, irqCtl_ff};
		else if (regAddr == `ADR_IMASK_L)
			rdMux = {3'h0, irqMask_ff};
		else if (regAddr == `ADR_IFLAG_L)
			rdMux = {3'h0, irqFlags_ff};
		else if (regAddr == `ADR_PMASK_L)
			rdMux = pinMaskW[7:0];
		else if (regAddr == `ADR_PMASK_M)
			rdMux = pinMaskW[15:8];
		else if (regAddr == `ADR_PMASK_H)
			rdMux = pinMaskW[23:16];
		else if (regAddr == `ADR_PFLAG_L)
			rdMux = pinFlagsW[7:0];
		else if (regAddr == `ADR_PFLAG_M)
			rdMux = pinFlagsW[15:8];
		else if (regAddr == `ADR_PFLAG_H)
			rdMux = pinFlagsW[23:16];
		else
			rdMux = 8'h00;
	end

	// ==========================================================
	// Hot-key debounce, time from select field
	logic [NUM_PINS-1:0] dbSample_ff, pinStable_ff;
	logic [15:0] dbCnt_ff;
	wire [15:0] dbLimit = dbCycles(dbSel_ff);
	wire pinMoved = pinSync_ff != dbSample_ff;
	wire dbAccept = ~pinMoved & (dbCnt_ff == dbLimit - 16'h0001);
	assign pinEvt = dbAccept ? (pinStable_ff ^ dbSample_ff) : '0;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{dbSample_ff, pinStable_ff} <= '0;
			dbCnt_ff <= 16'h0000;
		end
		else
		begin
			dbSample_ff <= pinSync_ff;
			pinStable_ff <= dbAccept ? dbSample_ff : pinStable_ff;
			if (pinMoved)
				dbCnt_ff <= 16'h0000;
			else if (dbCnt_ff < dbLimit)
				dbCnt_ff <= dbCnt_ff + 16'h0001;
		end
	end

	// ==========================================================
	// Interrupt output
	logic irqPendLast_ff, irqPinOe_ff, irqPinOut_ff;
	logic [15:0] pulseCnt_ff;
	wire irqPend = irqCtl_ff[`GATE_BIT] & (|(irqFlags_ff & irqMask_ff));
	wire pendRise = irqPend & ~irqPendLast_ff;
	wire [15:0] nxt_pulse = pendRise ? 16'(PULSE_CYC) :
		(pulseCnt_ff != 16'h0000) ? pulseCnt_ff - 16'h0001 : 16'h0000;
	wire nxt_irqOn = irqCtl_ff[`GATE_BIT] & (irqCtl_ff[`TYPE_BIT] ?
		(nxt_pulse != 16'h0000) : irqPend);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{irqPendLast_ff, irqPinOe_ff, irqPinOut_ff} <= 3'h0;
			pulseCnt_ff <= 16'h0000;
		end
		else
		begin
			irqPendLast_ff <= irqPend;
			pulseCnt_ff <= nxt_pulse;
			irqPinOe_ff <= nxt_irqOn;
			irqPinOut_ff <= ~(nxt_irqOn ^ irqCtl_ff[`POL_BIT]);
		end
	end
	assign irqPinOe = irqPinOe_ff;
	assign irqPinOut = irqPinOut_ff;

	// ==========================================================
	// Power state machine and hibernate idle counter
	pwr_state_t pwr_ff, nxt_pwr;
	logic [15:0] phase_ff, hibCnt_ff;
	logic hibArmed_ff, ourTxn_ff, clkRun_ff, oscOn_ff, hib_ff;
	// Wake sources run on the free clock, not the gated one
	wire wakeOther = (|irqSrcEvt) | pinMoved | addrHit |
		(pinSync_ff != pinStable_ff);
	wire hibDue = hibArmed_ff & (hibCnt_ff == 16'(HIB_CYC) - 16'h0001) &
		~keyHeld & keyFifoEmpty;
	wire wakeToOper = (pwr_ff != P_OPER) & (nxt_pwr == P_OPER) &
		~addrHit & ~sysRst_ff;
	wire armStart = (stopSeen & ourTxn_ff) | (addrMiss & ~hibArmed_ff) |
		wakeToOper;
	wire nxt_armed = ~sysRst_ff & ~addrHit & (nxt_pwr != P_HIBER) &
		(armStart | hibArmed_ff);

	always_comb
	begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			P_OPER:
				if (hibDue)
					nxt_pwr = P_HIBER;
			P_HIBER:
				if (keyHeld)
					nxt_pwr = P_KEYWAKE;
				else if (wakeOther)
					nxt_pwr = P_OPER;
			P_KEYWAKE:
				if (phase_ff == 16'(KEYWAKE_CYC) - 16'h0001)
					nxt_pwr = P_KEYCHK;
			default:
				if (!keyHeld)
					nxt_pwr = P_HIBER;
				else if (phase_ff == dbLimit - 16'h0001)
					nxt_pwr = P_OPER;
		endcase
		if (sysRst_ff)
			nxt_pwr = P_OPER;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pwr_ff <= P_OPER;
			{phase_ff, hibCnt_ff} <= 32'h0000_0000;
			{hibArmed_ff, ourTxn_ff, hib_ff} <= 3'h0;
			{clkRun_ff, oscOn_ff} <= 2'b11;
		end
		else
		begin
			pwr_ff <= nxt_pwr;
			phase_ff <= (nxt_pwr != pwr_ff) ? 16'h0000 : phase_ff + 16'h0001;
			hibArmed_ff <= nxt_armed;
			if (armStart)
				hibCnt_ff <= 16'h0000;
			else if (hibArmed_ff && hibCnt_ff < 16'(HIB_CYC) - 16'h0001)
				hibCnt_ff <= hibCnt_ff + 16'h0001;
			ourTxn_ff <= addrHit | (ourTxn_ff & ~stopSeen);
			clkRun_ff <= nxt_pwr == P_OPER || nxt_pwr == P_KEYCHK;
			oscOn_ff <= nxt_pwr != P_HIBER;
			hib_ff <= nxt_pwr == P_HIBER;
		end
	end
	assign clkRun = clkRun_ff;
	assign oscOn = oscOn_ff;
	assign hibernating = hib_ff;

	// ==========================================================
	// Checks
	property p_chip_identity;
		@(posedge ref_clk) disable iff (!rst_b)
		(regAddr == `ADR_CHIP_IDENTITY) |-> (rdMux == CHIP_IDENTITY_VAL);
	endproperty
	a_chip_identity: assert property (p_chip_identity) else $error("chip_identity wrong");
	property p_soft_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(softRst_ff) |-> ##1 blockReset ##[1:2] !softRst_ff;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft stuck");
	property p_db_default;
		@(posedge ref_clk) disable iff (!rst_b)
		blockReset |=> (debounceSel == 2'b11);
	endproperty
	a_db_default: assert property (p_db_default) else $error("db reset");
	property p_hib_gate;
		@(posedge ref_clk) disable iff (!rst_b)
		(pwr_ff == P_HIBER) |-> (!clkRun && !oscOn && hibernating);
	endproperty
	a_hib_gate: assert property (p_hib_gate) else $error("clock on");
	property p_reset_oper;
		@(posedge ref_clk) disable iff (!rst_b)
		blockReset |=> (pwr_ff == P_OPER && clkRun);
	endproperty
	a_reset_oper: assert property (p_reset_oper) else $error("no oper");
	property p_hib_timed;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(hibernating) && !$past(blockReset) &&
			$past(pwr_ff == P_OPER) |->
			$past(hibCnt_ff) == 16'(HIB_CYC) - 16'h0001;
	endproperty
	a_hib_timed: assert property (p_hib_timed) else $error("early sleep");
	property p_hib_quiet;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(hibernating) && $past(pwr_ff == P_OPER) |->
			$past(!keyHeld && keyFifoEmpty);
	endproperty
	a_hib_quiet: assert property (p_hib_quiet) else $error("data lost");
	property p_addr_restart;
		@(posedge ref_clk) disable iff (!rst_b)
		addrHit |=> !hibArmed_ff;
	endproperty
	a_addr_restart: assert property (p_addr_restart) else $error("armed");
	property p_gate_off;
		@(posedge ref_clk) disable iff (!rst_b)
		!irqCtl_ff[`GATE_BIT] |=> !irqPinOe;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("irq ungated");
	property p_polarity;
		@(posedge ref_clk) disable iff (!rst_b)
		irqPinOe |-> (irqPinOut == $past(irqCtl_ff[`POL_BIT]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("bad level");
endmodule : system_power_irq_control
`default_nettype wire

// file: bench/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host master on the register port, open-drain SDA with pull-up
module i2c_host_model
(
	input wire logic ref_clk,
	input wire logic sdaOe,
	output logic sclIn,
	output wire logic sdaIn
);
	logic pullLow;
	logic s;
	assign sdaIn = !(pullLow || sdaOe);
	initial
	begin
		sclIn = 1'b1;
		pullLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic bitx(input logic b, output logic smp);
		pullLow <= !b;
		tick(3);
		sclIn <= 1'b1;
		tick(4);
		smp = sdaIn;
		sclIn <= 1'b0;
		tick(1);
	endtask : bitx
	// Start or repeated start; a sleeping device wakes only on the address match after it
	task automatic start;
		pullLow <= 1'b0;
		tick(4);
		sclIn <= 1'b1;
		tick(4);
		pullLow <= 1'b1;
		tick(4);
		sclIn <= 1'b0;
		tick(1);
	endtask : start
	task automatic stop;
		pullLow <= 1'b1;
		tick(4);
		sclIn <= 1'b1;
		tick(4);
		pullLow <= 1'b0;
		tick(4);
	endtask : stop
	task automatic wrByte(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(v[i], s);
		bitx(1'b1, s);
		ack = !s;
	endtask : wrByte
	task automatic rdByte(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, v[i]);
		bitx(last, s);
	endtask : rdByte
endmodule : i2c_host_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
	failures++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
	import spic_pkg::*;
	localparam logic [7:0] CHIP = 8'h5a; // Arbitrary value
	localparam logic [7:0] REV = 8'h03; // Arbitrary value
	localparam int HIB = 400;
	logic ref_clk = 1'b0, rst_b = 1'b0, extResetPinB;
	logic lowVoltageDet, keyHeld, keyFifoEmpty;
	logic [4:0] irqSrcEvt;
	logic [17:0] hotKeyPins;
	int hk;
	wire logic sclIn, sdaIn;
	logic sdaOut, sdaOe, clkRun, oscOn, hibernating, blockReset;
	logic irqPinOut, irqPinOe, a, rstSeen;
	logic [1:0] debounceSel;
	logic [7:0] d;
	logic [7:0] mdl [16];
	logic [7:0] wm [16] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h07, 8'h00,
		8'h1f, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h03, 8'h00, 8'h00, 8'h00};
	int failures = 0, checked = 0, cycles = 0;
	system_power_irq_control #(.DB_CYC0(20), .DB_CYC1(40), .DB_CYC2(60),
		.DB_CYC3(80), .HIB_CYC(HIB), .KEYWAKE_CYC(10), .PULSE_CYC(16),
		.CHIP_IDENTITY_VAL(CHIP), .REV_ID_VAL(REV)) DUT (.ref_clk(ref_clk),
		.rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .extResetPinB(extResetPinB), .keyHeld(keyHeld),
		.lowVoltageDet(lowVoltageDet), .keyFifoEmpty(keyFifoEmpty),
		.irqSrcEvt(irqSrcEvt), .hotKeyPins(hotKeyPins), .clkRun(clkRun),
		.oscOn(oscOn), .hibernating(hibernating), .blockReset(blockReset),
		.debounceSel(debounceSel), .irqPinOut(irqPinOut),
		.irqPinOe(irqPinOe));
	i2c_host_model host (.ref_clk(ref_clk), .sdaOe(sdaOe), .sclIn(sclIn),
		.sdaIn(sdaIn));
	initial forever #5 ref_clk = !ref_clk;
	// ============================================================
	// Helpers
	task automatic summarize;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	always @(posedge ref_clk)
	begin
		cycles++;
		if (blockReset === 1'b1)
			rstSeen <= 1'b1;
		if (cycles == 60000)
		begin
			failures++;
			summarize();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic initModel;
		foreach (mdl[i])
			mdl[i] = 8'h00;
		mdl[0] = CHIP;
		mdl[1] = REV;
		mdl[2] = 8'h06;
	endtask : initModel
	task automatic addr(input logic [7:0] r);
		host.start();
		host.wrByte(8'h88, a);
		`CHK("own address ack", 1'b1, a)
		host.wrByte(r, a);
	endtask : addr
	task automatic wr(input logic [7:0] r, input logic [7:0] v, input int n);
		addr(r);
		for (int i = 0; i < n; i++)
		begin
			host.wrByte(v + 8'(i), a);
			mdl[(r + i) % 16] = (v + 8'(i)) & wm[(r + i) % 16];
		end
		host.stop();
		if (r == 8'h02 && v[7])
			initModel();
	endtask : wr
	task automatic rd(input logic [7:0] r, input int n);
		addr(r);
		host.start();
		host.wrByte(8'h89, a);
		for (int i = 0; i < n; i++)
		begin
			host.rdByte(i == n - 1, d);
			`CHK("register", mdl[(r + i) % 16], d)
			if ((r + i) % 16 inside {8, 13, 14, 15})
				mdl[(r + i) % 16] = 8'h00;
		end
		host.stop();
	endtask : rd
	task automatic foreign;
		host.start();
		host.wrByte(8'h8a, a);
		`CHK("foreign ack", 1'b0, a)
		host.stop();
	endtask : foreign
	task automatic evt(input int k);
		irqSrcEvt <= 5'(1 << k);
		tick(1);
		irqSrcEvt <= 5'h00;
		mdl[8][k] = 1'b1;
	endtask : evt
	// ============================================================
	// Main sequence
	initial
	begin
		void'($urandom(70));
		extResetPinB <= 1'b1;
		{lowVoltageDet, keyHeld, keyFifoEmpty} <= 3'b001;
		irqSrcEvt <= 5'h00;
		hotKeyPins <= 18'h00000;
		initModel();
		rstSeen = 1'b0;
		tick(3);
		rst_b <= 1'b1;
		tick(3);
		`CHK("debounce", 2'b11, debounceSel)
		`CHK("clock on", 2'b11, {clkRun, oscOn})
		`CHK("sda drive", 1'b0, sdaOut)
		rd(8'h00, 16);
		foreign();
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h02, {1'b0, 4'($urandom), 2'(k), 1'($urandom)}, 1);
			`CHK("debounce", 2'(k), debounceSel)
			rd(8'h02, 1);
		end
		wr(8'h04, 8'($urandom), 9);
		rd(8'h04, 12);
		for (int p = 0; p < 2; p++)
		begin
			wr(8'h04, {5'h00, 1'(p), 2'b01}, 1);
			wr(8'h06, 8'h01, 1);
			evt(0);
			tick(30);
			`CHK("irq level", {1'b1, 1'(p)}, {irqPinOe, irqPinOut})
			rd(8'h08, 1);
			tick(4);
			`CHK("irq cleared", 1'b0, irqPinOe)
		end
		wr(8'h06, 8'h02, 1);
		wr(8'h04, 8'h07, 1);
		evt(1);
		tick(6);
		`CHK("pulse on", 1'b1, irqPinOe)
		tick(20);
		`CHK("pulse off", 1'b0, irqPinOe)
		wr(8'h04, 8'h04, 1);
		evt(0);
		tick(6);
		`CHK("gated", 1'b0, irqPinOe)
		rd(8'h06, 3);
		hk = $urandom % 8;
		wr(8'h0a, 8'(1 << hk), 1);
		wr(8'h06, 8'h08, 1);
		wr(8'h04, 8'h05, 1);
		hotKeyPins <= 18'(1 << hk);
		tick(70);
		`CHK("hot key early", 1'b0, irqPinOe)
		tick(30);
		`CHK("hot key irq", 1'b1, irqPinOe)
		mdl[8][3] = 1'b1;
		mdl[13] = 8'(1 << hk);
		rd(8'h08, 1);
		rd(8'h0d, 1);
		keyFifoEmpty <= 1'b0;
		tick(HIB + 20);
		`CHK("queue pending", 1'b0, hibernating)
		keyFifoEmpty <= 1'b1;
		rd(8'h00, 1);
		foreign();
		tick(HIB - 140);
		`CHK("still awake", 1'b0, hibernating)
		tick(80);
		`CHK("asleep", 3'b100, {hibernating, clkRun, oscOn})
		evt(2);
		tick(4);
		`CHK("event wake", 1'b0, hibernating)
		tick(HIB + 20);
		`CHK("asleep again", 1'b1, hibernating)
		keyHeld <= 1'b1;
		tick(120);
		`CHK("valid key", 2'b01, {hibernating, clkRun})
		tick(HIB + 20);
		`CHK("key held", 1'b0, hibernating)
		keyHeld <= 1'b0;
		tick(HIB + 20);
		`CHK("keys released", 1'b1, hibernating)
		keyHeld <= 1'b1;
		tick(3);
		`CHK("key wakes", 2'b01, {hibernating, oscOn})
		keyHeld <= 1'b0;
		tick(120);
		`CHK("bounce sleeps", 1'b1, hibernating)
		rd(8'h00, 1);
		`CHK("host wake", 1'b0, hibernating)
		tick(HIB + 20);
		extResetPinB <= 1'b0;
		tick(6);
		`CHK("pin reset", 2'b01, {hibernating, blockReset})
		extResetPinB <= 1'b1;
		initModel();
		tick(6);
		lowVoltageDet <= 1'b1;
		tick(6);
		`CHK("low voltage reset", 1'b1, blockReset)
		lowVoltageDet <= 1'b0;
		tick(6);
		rstSeen <= 1'b0;
		host.start();
		host.wrByte(8'h00, a);
		host.wrByte(8'h06, a);
		host.stop();
		`CHK("bus reset", 1'b1, rstSeen)
		wr(8'h04, 8'($urandom), 9);
		rstSeen <= 1'b0;
		wr(8'h02, 8'h82, 1);
		tick(10);
		`CHK("soft reset", 1'b1, rstSeen)
		rd(8'h00, 16);
		summarize();
	end
endmodule : testbench
`default_nettype wire
